/* hw/cic_core_irq.v */
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "cic_defs.vh"
// Behaviour
// - Twelve sources, each with its own enable bit and flag bit.
// - Any reset leaves global and individual enables cleared; nothing vectors.
// - Vector needs global and source enable; peripheral sources also group enable.
// - Flags set on their event whatever the enables are.
// - Accepted request flushes prefetch, clears global enable, pushes PC, loads 0004h.
// - With global enable clear events only flag; serviced once it is set.
// - Return instruction pops PC and sets global enable together.
// - Synchronous source reaches vector execution three instruction cycles later.
// - Asynchronous pin source reaches vector in three or four cycles.
// - Latency does not depend on single- or two-cycle instruction.
// - Pin flag settable in fourth and first phase, sampled each first phase.
// - Interrupt wake with global enable runs PC+1 before loading vector.
// - Interrupt wake sets time-out bit, clears power-down bit, others kept.
// - Wake cause leaves its flag set in control or peripheral flags.
// - Only return PC is saved on entry; nothing else.
// - Pin edge select one means rising edge, zero falling edge.

module cic_core_irq #(
	parameter PFLAG_B_BITS = `CIC_PFLAG_B_BITS
) (
	input wire clk, // 25 MHz core clock
	input wire reset, // asynchronous, active high
	input wire [5:0] avs_address, // byte address
	input wire avs_read, // read request
	input wire avs_write, // write request
	input wire [31:0] avs_writedata, // write data
	output reg [31:0] avs_readdata, // read data
	output wire avs_waitrequest, // stall
	input wire tmr0_ovf_evt, // timer overflow pulse
	input wire portb_chg_evt, // port change pulse
	input wire ext_irq_pin, // external pin level
	input wire [7:0] periph_evt_a, // peripheral group A pulses
	input wire [PFLAG_B_BITS-1:0] periph_evt_b, // peripheral group B pulses
	input wire sleep_active, // core is in Sleep
	input wire return_from_irq_instr, // return instruction executes
	output reg [1:0] cycle_phase, // instruction phase counter
	output wire first_cycle_phase, // phase one enable
	output reg flush_prefetch, // drop prefetched instruction
	output reg push_pc, // push current PC
	output reg load_vector, // load PC with vector
	output wire [12:0] vector_addr, // vector address
	output reg pop_pc, // pop PC from stack
	output reg wake_up, // leave Sleep
	output wire irq // block interrupt
);

	localparam ST_IDLE = 2'd0;
	localparam ST_FLUSH = 2'd1;
	localparam ST_PUSH = 2'd2;
	localparam ST_WAKE = 2'd3;

	reg [7:0] ctrl_ff;
	reg [7:0] pflag_a_ff;
	reg [PFLAG_B_BITS-1:0] pflag_b_ff;
	reg [7:0] pen_a_ff;
	reg [PFLAG_B_BITS-1:0] pen_b_ff;
	reg [7:0] status_ff;
	reg [7:0] option_ff;
	reg [2:0] evt_stat_ff;
	reg [2:0] evt_mask_ff;
	reg [1:0] state_ff;
	reg ack_ff;
	reg pin_ff;
	reg pin_pend_ff;
	reg [1:0] nxt_state;

	wire fourth_cycle_phase;
	wire wr_en;
	wire pin_edge;
	wire pin_window;
	wire core_pend;
	wire periph_pend;
	wire any_pend;
	wire vec_req;
	wire take_vec;
	wire do_wake;
	wire [2:0] evt_set;

	// ------------------------------------------------------------
	// Phase divider: four clocks make one instruction cycle
	// ------------------------------------------------------------
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			cycle_phase <= 2'h0;
		end else begin
			cycle_phase <= cycle_phase + 2'h1;
		end
	end
	assign first_cycle_phase = (cycle_phase == 2'h0);
	assign fourth_cycle_phase = (cycle_phase == 2'h3);

	// ------------------------------------------------------------
	// Avalon slave: one wait cycle, the second edge completes
	// ------------------------------------------------------------
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
	assign wr_en = avs_write & ack_ff;

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ack_ff <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			ack_ff <= (avs_read | avs_write) & ~ack_ff;
			if (avs_read & ~ack_ff) begin
				case (avs_address)
				`CIC_OFS_CTRL: avs_readdata <= {24'h0, ctrl_ff};
				`CIC_OFS_PFLAG_A: avs_readdata <= {24'h0, pflag_a_ff};
				`CIC_OFS_PFLAG_B: avs_readdata <= {{(32-PFLAG_B_BITS){1'b0}}, pflag_b_ff};
				`CIC_OFS_PEN_A: avs_readdata <= {24'h0, pen_a_ff};
				`CIC_OFS_PEN_B: avs_readdata <= {{(32-PFLAG_B_BITS){1'b0}}, pen_b_ff};
				`CIC_OFS_STATUS: avs_readdata <= {24'h0, status_ff};
				`CIC_OFS_OPTION: avs_readdata <= {24'h0, option_ff};
				`CIC_OFS_EVT_STAT: avs_readdata <= {29'h0, evt_stat_ff};
				`CIC_OFS_EVT_MASK: avs_readdata <= {29'h0, evt_mask_ff};
				`CIC_OFS_SEQ: avs_readdata <= {30'h0, state_ff};
				default: avs_readdata <= 32'h0;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// External pin edge detection
	// ------------------------------------------------------------
	// An edge outside the fourth or first phase is held pending until the
	// next fourth phase, so it is still sampled at the next first phase.
	assign pin_edge = option_ff[0] ? (ext_irq_pin & ~pin_ff) : (~ext_irq_pin & pin_ff);
	assign pin_window = fourth_cycle_phase | first_cycle_phase;

	// The detector resets low to match a pin that idles low; a pin held
	// high through reset shows one rising edge after release.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			pin_ff <= 1'b0;
			pin_pend_ff <= 1'b0;
		end else begin
			pin_ff <= ext_irq_pin;
			pin_pend_ff <= (pin_pend_ff | pin_edge) & ~pin_window;
		end
	end

	// ------------------------------------------------------------
	// Request logic
	// ------------------------------------------------------------
	assign core_pend = (ctrl_ff[`CIC_CTRL_T0IE] & ctrl_ff[`CIC_CTRL_T0IF])
		| (ctrl_ff[`CIC_CTRL_EXTIE] & ctrl_ff[`CIC_CTRL_EXTIF])
		| (ctrl_ff[`CIC_CTRL_RBIE] & ctrl_ff[`CIC_CTRL_RBIF]);
	assign periph_pend = |(pflag_a_ff & pen_a_ff) | |(pflag_b_ff & pen_b_ff);
	// The same gated pending term starts a wake, so the flag that woke the
	// core is still set when software looks for the cause.
	assign any_pend = core_pend | (ctrl_ff[`CIC_CTRL_GRP_EN] & periph_pend);
	assign vec_req = ctrl_ff[`CIC_CTRL_GLB_EN] & any_pend;
	// Sampling only at phase one and only when idle keeps latency
	// independent of the length of the running instruction.
	assign take_vec = first_cycle_phase & vec_req & (state_ff == ST_IDLE)
		& ~sleep_active;
	assign do_wake = sleep_active & first_cycle_phase & (state_ff == ST_IDLE)
		& any_pend;
	assign vector_addr = `CIC_VECTOR_ADDR;

	// ------------------------------------------------------------
	// Vector sequencer, one step per instruction cycle
	// ------------------------------------------------------------
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
		ST_IDLE: begin
			if (do_wake & ctrl_ff[`CIC_CTRL_GLB_EN]) begin
				nxt_state = ST_WAKE;
			end else if (take_vec) begin
				nxt_state = ST_FLUSH;
			end
		end
		ST_WAKE: begin
			if (first_cycle_phase) begin
				nxt_state = ST_FLUSH;
			end
		end
		ST_FLUSH: begin
			if (first_cycle_phase) begin
				nxt_state = ST_PUSH;
			end
		end
		ST_PUSH: begin
			if (first_cycle_phase) begin
				nxt_state = ST_IDLE;
			end
		end
		default: nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			state_ff <= ST_IDLE;
			flush_prefetch <= 1'b0;
			push_pc <= 1'b0;
			load_vector <= 1'b0;
			pop_pc <= 1'b0;
			wake_up <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			// Event sampled at phase one is flushed in that cycle, the PC is
			// pushed in the next and the vector runs from the third.
			flush_prefetch <= take_vec
				| ((state_ff == ST_WAKE) & first_cycle_phase);
			push_pc <= (state_ff == ST_FLUSH) & first_cycle_phase;
			load_vector <= (state_ff == ST_PUSH) & first_cycle_phase;
			pop_pc <= return_from_irq_instr;
			wake_up <= do_wake;
		end
	end

	// ------------------------------------------------------------
	// Control, flag and enable registers
	// ------------------------------------------------------------
	// Hardware set wins over a software clear in the same cycle.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrl_ff <= `CIC_RST_CTRL;
			pflag_a_ff <= `CIC_RST_PFLAG;
			pflag_b_ff <= {PFLAG_B_BITS{1'b0}};
			pen_a_ff <= `CIC_RST_PEN;
			pen_b_ff <= {PFLAG_B_BITS{1'b0}};
			option_ff <= `CIC_RST_OPTION;
		end else begin
			if (wr_en && avs_address == `CIC_OFS_CTRL) begin
				ctrl_ff[7:3] <= avs_writedata[7:3];
			end
			if (take_vec | (state_ff == ST_WAKE)) begin
				ctrl_ff[`CIC_CTRL_GLB_EN] <= 1'b0;
			end else if (return_from_irq_instr) begin
				ctrl_ff[`CIC_CTRL_GLB_EN] <= 1'b1;
			end
			ctrl_ff[`CIC_CTRL_T0IF] <= tmr0_ovf_evt | ((wr_en && avs_address == `CIC_OFS_CTRL)
				? avs_writedata[`CIC_CTRL_T0IF] : ctrl_ff[`CIC_CTRL_T0IF]);
			ctrl_ff[`CIC_CTRL_EXTIF] <= ((pin_edge | pin_pend_ff) & pin_window)
				| ((wr_en && avs_address == `CIC_OFS_CTRL)
				? avs_writedata[`CIC_CTRL_EXTIF] : ctrl_ff[`CIC_CTRL_EXTIF]);
			ctrl_ff[`CIC_CTRL_RBIF] <= portb_chg_evt | ((wr_en && avs_address == `CIC_OFS_CTRL)
				? avs_writedata[`CIC_CTRL_RBIF] : ctrl_ff[`CIC_CTRL_RBIF]);
			pflag_a_ff <= periph_evt_a | ((wr_en && avs_address == `CIC_OFS_PFLAG_A)
				? avs_writedata[7:0] : pflag_a_ff);
			pflag_b_ff <= periph_evt_b | ((wr_en && avs_address == `CIC_OFS_PFLAG_B)
				? avs_writedata[PFLAG_B_BITS-1:0] : pflag_b_ff);
			if (wr_en && avs_address == `CIC_OFS_PEN_A) begin
				pen_a_ff <= avs_writedata[7:0];
			end
			if (wr_en && avs_address == `CIC_OFS_PEN_B) begin
				pen_b_ff <= avs_writedata[PFLAG_B_BITS-1:0];
			end
			if (wr_en && avs_address == `CIC_OFS_OPTION) begin
				option_ff <= {7'h0, avs_writedata[0]};
			end
		end
	end

	// ------------------------------------------------------------
	// Core status: time-out and power-down bits are hardware owned
	// ------------------------------------------------------------
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			status_ff <= `CIC_RST_STATUS;
		end else begin
			if (wr_en && avs_address == `CIC_OFS_STATUS) begin
				status_ff[7:5] <= avs_writedata[7:5];
				status_ff[2:0] <= avs_writedata[2:0];
			end
			if (do_wake) begin
				status_ff[`CIC_STAT_TIMEOUT] <= 1'b1;
				status_ff[`CIC_STAT_PWRDN] <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Block interrupt: sticky events, write one to clear
	// ------------------------------------------------------------
	// The mask register has the same layout as the event status register.
	assign evt_set = {return_from_irq_instr, do_wake, take_vec};
	assign irq = |(evt_stat_ff & evt_mask_ff);

	always @(posedge clk or posedge reset) begin
		if (reset) begin
			evt_stat_ff <= `CIC_RST_EVT;
			evt_mask_ff <= `CIC_RST_EVT;
		end else begin
			evt_stat_ff <= evt_set | (evt_stat_ff
				& ~((wr_en && avs_address == `CIC_OFS_EVT_STAT) ? avs_writedata[2:0] : 3'h0));
			if (wr_en && avs_address == `CIC_OFS_EVT_MASK) begin
				evt_mask_ff <= avs_writedata[2:0];
			end
		end
	end

endmodule // cic_core_irq

/* shared/cic_defs.vh */
`ifndef CIC_DEFS_VH
`define CIC_DEFS_VH

// ------------------------------------------------------------
// Register byte offsets (word aligned)
// ------------------------------------------------------------
`define CIC_OFS_CTRL 6'h00
`define CIC_OFS_PFLAG_A 6'h04
`define CIC_OFS_PFLAG_B 6'h08
`define CIC_OFS_PEN_A 6'h0c
`define CIC_OFS_PEN_B 6'h10
`define CIC_OFS_STATUS 6'h14
`define CIC_OFS_OPTION 6'h18
`define CIC_OFS_EVT_STAT 6'h1c
`define CIC_OFS_EVT_MASK 6'h20
`define CIC_OFS_SEQ 6'h24

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CIC_CTRL_GLB_EN 7
`define CIC_CTRL_GRP_EN 6
`define CIC_CTRL_T0IE 5
`define CIC_CTRL_EXTIE 4
`define CIC_CTRL_RBIE 3
`define CIC_CTRL_T0IF 2
`define CIC_CTRL_EXTIF 1
`define CIC_CTRL_RBIF 0
`define CIC_STAT_TIMEOUT 4
`define CIC_STAT_PWRDN 3
`define CIC_EVT_VECTOR 0
`define CIC_EVT_WAKE 1
`define CIC_EVT_RETURN 2

// ------------------------------------------------------------
// Reset values, vector and timing
// ------------------------------------------------------------
`define CIC_RST_CTRL 8'h00
`define CIC_RST_PFLAG 8'h00
`define CIC_RST_PEN 8'h00
`define CIC_RST_STATUS 8'h18
`define CIC_RST_OPTION 8'h01
`define CIC_RST_EVT 3'h0
`define CIC_VECTOR_ADDR 13'h0004
`define CIC_PHASES 4
`define CIC_PFLAG_B_BITS 1

`endif

/* verif/cic_core_irq_monitor.sv */
`timescale 1ns/1ps
module cic_core_irq_monitor (
	input wire logic clk, // clock
	input wire logic reset, // reset
	input wire logic first_cycle_phase, // phase one
	input wire logic flush_prefetch, // flush
	input wire logic push_pc, // push
	input wire logic load_vector, // vector load
	input wire logic [12:0] vector_addr, // vector
	input wire logic pop_pc, // pop
	input wire logic wake_up, // wake
	input wire logic return_from_irq_instr, // return
	input wire logic irq // interrupt
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	AST_FLUSH_PUSH: assert property (flush_prefetch |-> ##4 push_pc)
		else $error("push did not follow flush");
	AST_PUSH_LOAD: assert property (push_pc |-> ##4 (load_vector && vector_addr == 13'h0004))
		else $error("vector load missing or wrong");
	AST_LOAD_CAUSE: assert property (load_vector |-> $past(flush_prefetch, 8))
		else $error("vector load without flush");
	AST_NO_REENTRY: assert property (flush_prefetch |=> !flush_prefetch [*7])
		else $error("second vector while busy");
	AST_RET_POP: assert property (return_from_irq_instr |=> pop_pc)
		else $error("return did not pop");
	AST_RESET_QUIET: assert property ($fell(reset) |-> !irq && !flush_prefetch)
		else $error("activity after reset");
	AST_PHASE: assert property (first_cycle_phase |=> !first_cycle_phase [*3] ##1 first_cycle_phase)
		else $error("phase one not every fourth clock");
	AST_WAKE_FIRST: assert property (wake_up |=> !flush_prefetch [*3])
		else $error("vector before next instruction");
	COV_VEC: cover property (load_vector);
	COV_WAKE: cover property (wake_up ##[1:20] load_vector);
	COV_RET: cover property (pop_pc);
endmodule // cic_core_irq_monitor

bind cic_core_irq cic_core_irq_monitor i_mon (.clk(clk), .reset(reset),
	.first_cycle_phase(first_cycle_phase), .flush_prefetch(flush_prefetch),
	.push_pc(push_pc), .load_vector(load_vector), .vector_addr(vector_addr),
	.pop_pc(pop_pc), .wake_up(wake_up), .return_from_irq_instr(return_from_irq_instr),
	.irq(irq));

/* verif/cic_seq_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Core sequencer stand-in
// ----------------------------------------
module cic_seq_model (
	input wire logic clk, // clock
	input wire logic reset, // reset
	input wire logic ret_req, // run return
	input wire logic [7:0] ret_dly, // return delay
	input wire logic sleep_req, // enter Sleep
	input wire logic wake_up, // wake pulse
	output logic return_from_irq_instr, // return pulse
	output logic sleep_active // asleep
);
	logic [7:0] cnt_ff;
	// A long delay lets service code clear its flags before returning.
	always @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_ff <= 8'h00;
			return_from_irq_instr <= 1'b0;
			sleep_active <= 1'b0;
		end else begin
			return_from_irq_instr <= (cnt_ff == 8'h01);
			if (ret_req)
				cnt_ff <= ret_dly;
			else if (cnt_ff != 8'h00)
				cnt_ff <= cnt_ff - 8'h01;
			if (wake_up)
				sleep_active <= 1'b0;
			else if (sleep_req)
				sleep_active <= 1'b1;
		end
	end
endmodule // cic_seq_model

/* verif/cic_core_irq_test.sv */
`timescale 1ns/1ps
`include "cic_defs.vh"
module cic_core_irq_test;
	logic clk = 0;
	logic reset = 1;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 0;
	logic avs_write = 0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [10:0] ev = 11'h000;
	logic pin = 0;
	logic ret_req = 0;
	logic sleep_req = 0;
	logic sleep_active, ret_i, flush, load, pop, wake, irq;
	logic [1:0] phase;
	logic [7:0] q;
	int bad_count = 0;
	int n_tests = 0;
	int nfl = 0;
	int nld = 0;
	int npop = 0;
	int cyc = 0;
	int tl = 0;
	int tld = 0;
	always #20 clk = ~clk;
	cic_core_irq i_dut (.clk(clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.tmr0_ovf_evt(ev[0]), .portb_chg_evt(ev[1]), .ext_irq_pin(pin),
		.periph_evt_a(ev[9:2]), .periph_evt_b(ev[10:10]), .sleep_active(sleep_active),
		.return_from_irq_instr(ret_i), .cycle_phase(phase), .first_cycle_phase(),
		.flush_prefetch(flush), .push_pc(), .load_vector(load), .vector_addr(),
		.pop_pc(pop), .wake_up(wake), .irq(irq));
	cic_seq_model i_seq (.clk(clk), .reset(reset), .ret_req(ret_req), .ret_dly(8'd60),
		.sleep_req(sleep_req), .wake_up(wake), .return_from_irq_instr(ret_i),
		.sleep_active(sleep_active));
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (flush === 1'b1)
			nfl <= nfl + 1;
		if (pop === 1'b1)
			npop <= npop + 1;
		if (load === 1'b1) begin
			nld <= nld + 1;
			tld <= cyc;
		end
		if (cyc == 20000) begin
			bad_count++;
			end_of_test;
		end
	end
	task end_of_test;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_write <= 0;
		avs_read <= 0;
		@(posedge clk);
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask
	task rc(input logic [5:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(q, e);
	endtask
	task fire(input logic [10:0] m);
		@(posedge clk);
		ev <= m;
		tl = cyc;
		@(posedge clk);
		ev <= 11'h000;
	endtask
	// Waits for a counter to move; a stuck counter counts as a mismatch.
	task automatic wc(ref int c);
		int k;
		int n;
		k = c;
		n = 0;
		while (c == k && n < 200) begin
			@(posedge clk);
			n++;
		end
		chk(8'(c != k), 8'h01);
	endtask
	initial begin
		repeat (3) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		rc(`CIC_OFS_CTRL, 8'h00);
		rc(`CIC_OFS_STATUS, `CIC_RST_STATUS);
		rc(6'h3c, 8'h00);
		wr(`CIC_OFS_CTRL, 8'h20);
		fire(11'h7ff);
		repeat (8) @(posedge clk);
		rc(`CIC_OFS_CTRL, 8'h25);
		rc(`CIC_OFS_PFLAG_A, 8'hff);
		rc(`CIC_OFS_PFLAG_B, 8'h01);
		wr(`CIC_OFS_PEN_A, 8'h01);
		wr(`CIC_OFS_EVT_MASK, 8'h01);
		wr(`CIC_OFS_CTRL, 8'h80);
		repeat (12) @(posedge clk);
		chk(8'(nfl), 8'h00);
		wr(`CIC_OFS_CTRL, 8'hc0);
		wc(nld);
		rc(`CIC_OFS_CTRL, 8'h40);
		chk(irq, 1'b1);
		wr(`CIC_OFS_EVT_STAT, 8'h01);
		chk(irq, 1'b0);
		wr(`CIC_OFS_PFLAG_A, 8'h00);
		ret_req <= 1;
		@(posedge clk);
		ret_req <= 0;
		wc(npop);
		rc(`CIC_OFS_CTRL, 8'hc0);
		chk(8'(nfl), 8'h01);
		$display("test gating done");
		wr(`CIC_OFS_CTRL, 8'ha0);
		do @(negedge clk); while (phase !== 2'h1);
		fire(11'h001);
		wc(nld);
		chk(8'(tld - tl), 8'h0c);
		wr(`CIC_OFS_CTRL, 8'h90);
		@(posedge clk);
		pin <= 1;
		tl = cyc;
		wc(nld);
		chk(8'(tld - tl inside {[8:17]}), 8'h01);
		rc(`CIC_OFS_CTRL, 8'h12);
		wr(`CIC_OFS_OPTION, 8'h00);
		wr(`CIC_OFS_CTRL, 8'h00);
		pin <= 0;
		repeat (8) @(posedge clk);
		rc(`CIC_OFS_CTRL, 8'h02);
		$display("test latency done");
		wr(`CIC_OFS_CTRL, 8'ha0);
		sleep_req <= 1;
		@(posedge clk);
		sleep_req <= 0;
		fire(11'h001);
		wc(nld);
		rc(`CIC_OFS_STATUS, 8'h10);
		rc(`CIC_OFS_CTRL, 8'h24);
		$display("test sleep done");
		end_of_test;
	end
endmodule // cic_core_irq_test
